/* logic/gauge_pkg.sv */
package gauge_pkg;
  // AXI4-Lite byte addresses of the settings and status words.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEGAS_TIME = 8'h04;
  localparam logic [7:0] ADDR_SENS = 8'h08;
  localparam logic [7:0] ADDR_RLY_LO = 8'h0C;
  localparam logic [7:0] ADDR_RLY_HI = 8'h10;
  localparam logic [7:0] ADDR_AUTO_TRIP = 8'h14;
  localparam logic [7:0] ADDR_OVERP = 8'h18;
  localparam logic [7:0] ADDR_COMMS = 8'h1C;
  localparam logic [7:0] ADDR_PRESSURE = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_F1_HRS = 8'h28;
  localparam logic [7:0] ADDR_F2_HRS = 8'h2C;
  localparam logic [7:0] ADDR_D1_HRS = 8'h30;
  localparam logic [7:0] ADDR_D2_HRS = 8'h34;
  localparam logic [7:0] ADDR_PWR_HRS = 8'h38;

  // Control word bit positions (write 1 to the command bits).
  localparam int CTRL_FIL_ON = 0;
  localparam int CTRL_FIL_OFF = 1;
  localparam int CTRL_DEGAS_ON = 2;
  localparam int CTRL_DEGAS_OFF = 3;
  localparam int CTRL_EMIS_HI = 4;
  localparam int CTRL_FIL_SEL = 5;
  localparam int CTRL_RLY_TEST = 6;
  localparam int CTRL_RLY_FORCE = 7;
  localparam int CTRL_AUTO_EN = 8;

  // Pressures are log-coded: 16 * (exponent + 12) + mantissa step, with
  // mantissa steps 0..8 for 1.0..9.x; bigger code means higher pressure.
  localparam logic [7:0] P_1E11 = 8'h10;
  localparam logic [7:0] P_3E02 = 8'hA2;
  localparam logic [7:0] P_1E06 = 8'h60;
  localparam logic [7:0] P_5E06 = 8'h64;
  localparam logic [7:0] P_1E04 = 8'h80;
  localparam logic [7:0] P_5E02 = 8'hA4;
  localparam logic [7:0] P_1E03 = 8'h90;

  localparam logic [3:0] DEGAS_MIN_RST = 4'h2;
  localparam logic [3:0] DEGAS_MAX = 4'hA;
  localparam logic [6:0] SENS_MIN = 7'h02;
  localparam logic [6:0] SENS_MAX = 7'h63;
  localparam logic [6:0] SENS_RST = 7'h0A;
  localparam logic [3:0] ADDR_LO_RST = 4'h1;
  localparam logic [3:0] ADDR_HI_RST = 4'h0;
  localparam logic [3:0] BAUD_RST = 4'h4;

  localparam int CLK_HZ = 25_000_000;
  localparam int SEC_PER_MIN = 60;
  localparam int SEC_PER_TENTH_HOUR = 360;
  localparam int TICK_CYCLES = CLK_HZ;
endpackage

/* logic/gauge_setpoint_control.sv */
// Implementation choices: the AXI4-Lite slave port and the register addresses.
module gauge_setpoint_control #(
  parameter int TICK_CYCLES = gauge_pkg::TICK_CYCLES,
  parameter int HOUR_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] pressure_code,
  output logic fil_one_drive,
  output logic fil_two_drive,
  output logic degas_drive,
  output logic emission_high,
  output logic relay_drive,
  output logic [6:0] sensitivity,
  output logic [7:0] node_address,
  output logic [3:0] baud_select
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  logic [7:0] aw_q;
  logic aw_have_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic wr_ok;

  logic fil_on_q, emis_hi_q, fil_sel_q, rly_test_q, rly_force_q, auto_en_q;
  logic degas_q;
  logic [3:0] degas_min_q;
  logic [6:0] sens_q;
  logic [7:0] rly_lo_q, rly_hi_q, auto_trip_q, overp_q;
  logic [3:0] addr_lo_q, addr_hi_q, baud_q;
  logic [7:0] pres_s1_q, pres_s2_q, pres_s3_q, pres_q;
  logic relay_q;
  logic [TW-1:0] tick_q;
  logic tick;
  logic [5:0] sec_q;
  logic [8:0] tenth_q;
  logic [3:0] degas_elapsed_q;
  logic tenth_hr;
  logic [HOUR_W-1:0] f1_q, f2_q, d1_q, d2_q, pwr_q;
  logic eff_emis_hi;
  logic overp_trip;

  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;

  always_comb begin
    case (aw_q)
      gauge_pkg::ADDR_CTRL, gauge_pkg::ADDR_DEGAS_TIME, gauge_pkg::ADDR_SENS,
      gauge_pkg::ADDR_RLY_LO, gauge_pkg::ADDR_RLY_HI, gauge_pkg::ADDR_AUTO_TRIP,
      gauge_pkg::ADDR_OVERP, gauge_pkg::ADDR_COMMS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Address and data are captured independently; the response follows both.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_q <= wdata;
        ws_q <= wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? 2'h0 : 2'h2;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= 2'h0;
      case (araddr)
        gauge_pkg::ADDR_CTRL: rdata_q <= {23'h0, auto_en_q, rly_force_q, rly_test_q,
                                          fil_sel_q, emis_hi_q, degas_q, 1'b0,
                                          fil_on_q, 1'b0};
        gauge_pkg::ADDR_DEGAS_TIME: rdata_q <= {28'h0, degas_min_q};
        gauge_pkg::ADDR_SENS: rdata_q <= {25'h0, sens_q};
        gauge_pkg::ADDR_RLY_LO: rdata_q <= {24'h0, rly_lo_q};
        gauge_pkg::ADDR_RLY_HI: rdata_q <= {24'h0, rly_hi_q};
        gauge_pkg::ADDR_AUTO_TRIP: rdata_q <= {24'h0, auto_trip_q};
        gauge_pkg::ADDR_OVERP: rdata_q <= {24'h0, overp_q};
        gauge_pkg::ADDR_COMMS: rdata_q <= {20'h0, baud_q, addr_hi_q, addr_lo_q};
        gauge_pkg::ADDR_PRESSURE: rdata_q <= {24'h0, pres_q};
        gauge_pkg::ADDR_STATUS: rdata_q <= {28'h0, eff_emis_hi, relay_q, degas_q,
                                            fil_on_q};
        gauge_pkg::ADDR_F1_HRS: rdata_q <= 32'(f1_q);
        gauge_pkg::ADDR_F2_HRS: rdata_q <= 32'(f2_q);
        gauge_pkg::ADDR_D1_HRS: rdata_q <= 32'(d1_q);
        gauge_pkg::ADDR_D2_HRS: rdata_q <= 32'(d2_q);
        gauge_pkg::ADDR_PWR_HRS: rdata_q <= 32'(pwr_q);
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= 2'h2;
        end
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Pressure arrives from the measurement chain in another domain. The word is
  // taken only when two synchronised samples agree, so a code caught while its
  // bits change is never used.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pres_s1_q <= 8'hFF;
      pres_s2_q <= 8'hFF;
      pres_s3_q <= 8'hFF;
      pres_q <= 8'hFF;
    end else begin
      pres_s1_q <= pressure_code;
      pres_s2_q <= pres_s1_q;
      pres_s3_q <= pres_s2_q;
      if (pres_s2_q == pres_s3_q) pres_q <= pres_s2_q;
    end
  end

  // Settings; out-of-range values are refused and the old value kept.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      emis_hi_q <= 1'b0;
      fil_sel_q <= 1'b0;
      rly_test_q <= 1'b0;
      rly_force_q <= 1'b0;
      auto_en_q <= 1'b0;
      degas_min_q <= gauge_pkg::DEGAS_MIN_RST;
      sens_q <= gauge_pkg::SENS_RST;
      rly_lo_q <= gauge_pkg::P_1E06;
      rly_hi_q <= gauge_pkg::P_5E06;
      auto_trip_q <= gauge_pkg::P_1E04;
      overp_q <= gauge_pkg::P_5E02;
      addr_lo_q <= gauge_pkg::ADDR_LO_RST;
      addr_hi_q <= gauge_pkg::ADDR_HI_RST;
      baud_q <= gauge_pkg::BAUD_RST;
    end else if (wr_go && wr_ok && ws_q[0]) begin
      case (aw_q)
        gauge_pkg::ADDR_CTRL: begin
          emis_hi_q <= w_q[gauge_pkg::CTRL_EMIS_HI];
          fil_sel_q <= w_q[gauge_pkg::CTRL_FIL_SEL];
          rly_test_q <= w_q[gauge_pkg::CTRL_RLY_TEST];
          rly_force_q <= w_q[gauge_pkg::CTRL_RLY_FORCE];
        end
        gauge_pkg::ADDR_DEGAS_TIME:
          if (w_q[7:0] >= 8'(gauge_pkg::DEGAS_MIN_RST) && w_q[7:0] <= 8'(gauge_pkg::DEGAS_MAX))
            degas_min_q <= w_q[3:0];
        gauge_pkg::ADDR_SENS:
          if (in_range(w_q[7:0], 8'(gauge_pkg::SENS_MIN), 8'(gauge_pkg::SENS_MAX)))
            sens_q <= w_q[6:0];
        gauge_pkg::ADDR_RLY_LO:
          if (in_range(w_q[7:0], gauge_pkg::P_1E11, gauge_pkg::P_3E02))
            rly_lo_q <= w_q[7:0];
        gauge_pkg::ADDR_RLY_HI:
          if (in_range(w_q[7:0], gauge_pkg::P_1E11, gauge_pkg::P_3E02))
            rly_hi_q <= w_q[7:0];
        gauge_pkg::ADDR_AUTO_TRIP:
          if (in_range(w_q[7:0], gauge_pkg::P_1E06, gauge_pkg::P_1E04))
            auto_trip_q <= w_q[7:0];
        gauge_pkg::ADDR_OVERP:
          if (w_q[7:0] <= gauge_pkg::P_5E02)
            overp_q <= w_q[7:0];
        gauge_pkg::ADDR_COMMS: begin
          addr_lo_q <= w_q[3:0];
          addr_hi_q <= w_q[7:4];
          baud_q <= w_q[11:8];
        end
        default: begin
        end
      endcase
    end
    if (rst_b && wr_go && wr_ok && ws_q[1] && aw_q == gauge_pkg::ADDR_CTRL)
      auto_en_q <= w_q[gauge_pkg::CTRL_AUTO_EN];
  end

  // Auto switching runs 4 mA below the trip pressure, else 100 uA.
  assign eff_emis_hi = auto_en_q ? (pres_q < auto_trip_q) : emis_hi_q;
  assign overp_trip = eff_emis_hi ? (pres_q > gauge_pkg::P_1E03)
                                  : (pres_q > overp_q);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fil_on_q <= 1'b0;
    end else if (overp_trip) begin
      fil_on_q <= 1'b0;
    end else if (wr_go && aw_q == gauge_pkg::ADDR_CTRL && ws_q[0]) begin
      if (w_q[gauge_pkg::CTRL_FIL_OFF])
        fil_on_q <= 1'b0;
      else if (w_q[gauge_pkg::CTRL_FIL_ON])
        fil_on_q <= 1'b1;
    end
  end

  // One-second tick, seconds in a minute, and tenth-hour pacing.
  assign tick = (tick_q == TW'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tick_q <= '0;
      sec_q <= 6'h00;
      tenth_q <= 9'h000;
    end else begin
      tick_q <= tick ? '0 : tick_q + TW'(1);
      if (tick) begin
        sec_q <= (sec_q == 6'(gauge_pkg::SEC_PER_MIN - 1)) ? 6'h00 : sec_q + 6'h01;
        tenth_q <= (tenth_q == 9'(gauge_pkg::SEC_PER_TENTH_HOUR - 1)) ? 9'h000
                 : tenth_q + 9'h001;
      end
    end
  end
  assign tenth_hr = tick && (tenth_q == 9'(gauge_pkg::SEC_PER_TENTH_HOUR - 1));

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      degas_q <= 1'b0;
      degas_elapsed_q <= 4'h0;
    end else if (!fil_on_q || overp_trip) begin
      degas_q <= 1'b0;
    end else if (wr_go && aw_q == gauge_pkg::ADDR_CTRL && ws_q[0] &&
                 (w_q[gauge_pkg::CTRL_DEGAS_OFF] || w_q[gauge_pkg::CTRL_FIL_OFF])) begin
      // A filament-off command ends degas on the same edge.
      degas_q <= 1'b0;
    end else if (wr_go && aw_q == gauge_pkg::ADDR_CTRL && ws_q[0] &&
                 w_q[gauge_pkg::CTRL_DEGAS_ON]) begin
      degas_q <= 1'b1;
      degas_elapsed_q <= 4'h0;
    end else if (degas_q && tick && sec_q == 6'(gauge_pkg::SEC_PER_MIN - 1)) begin
      degas_elapsed_q <= degas_elapsed_q + 4'h1;
      if (degas_elapsed_q + 4'h1 >= degas_min_q)
        degas_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      f1_q <= '0;
      f2_q <= '0;
      d1_q <= '0;
      d2_q <= '0;
      pwr_q <= '0;
    end else if (tenth_hr) begin
      pwr_q <= pwr_q + HOUR_W'(1);
      if (fil_on_q && !fil_sel_q) f1_q <= f1_q + HOUR_W'(1);
      if (fil_on_q && fil_sel_q) f2_q <= f2_q + HOUR_W'(1);
      if (degas_q && !fil_sel_q) d1_q <= d1_q + HOUR_W'(1);
      if (degas_q && fil_sel_q) d2_q <= d2_q + HOUR_W'(1);
    end
  end

  // Setpoint order picks the switching direction; test mode overrides.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      relay_q <= 1'b0;
    end else if (rly_test_q) begin
      relay_q <= rly_force_q;
    end else if (rly_lo_q < rly_hi_q) begin
      if (pres_q < rly_lo_q) relay_q <= 1'b1;
      else if (pres_q > rly_hi_q) relay_q <= 1'b0;
    end else begin
      if (pres_q > rly_lo_q) relay_q <= 1'b1;
      else if (pres_q < rly_hi_q) relay_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fil_one_drive <= 1'b0;
      fil_two_drive <= 1'b0;
      degas_drive <= 1'b0;
      emission_high <= 1'b0;
    end else begin
      fil_one_drive <= fil_on_q && !fil_sel_q;
      fil_two_drive <= fil_on_q && fil_sel_q;
      degas_drive <= degas_q;
      emission_high <= eff_emis_hi;
    end
  end

  assign relay_drive = relay_q;
  assign sensitivity = sens_q;
  assign node_address = {addr_hi_q, addr_lo_q};
  assign baud_select = baud_q;

  a_fil_starts_off: assert property (@(posedge clk_sys)
    $rose(rst_b) |-> !fil_on_q)
    else $error("filament not off after reset");
  a_degas_needs_fil: assert property (@(posedge clk_sys) disable iff (!rst_b)
    degas_q |-> fil_on_q)
    else $error("degas without filament");
  a_one_filament: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(fil_one_drive && fil_two_drive))
    else $error("both filaments driven");
  a_relay_test: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rly_test_q |=> relay_q == $past(rly_force_q))
    else $error("relay test not followed");
  a_relay_low_on: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!rly_test_q && rly_lo_q < rly_hi_q && pres_q < rly_lo_q) |=> relay_q)
    else $error("relay not energized below low setpoint");
  a_relay_inv_on: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!rly_test_q && rly_lo_q > rly_hi_q && pres_q > rly_lo_q) |=> relay_q)
    else $error("relay not energized above low setpoint");
  a_setpoint_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
    in_range(rly_lo_q, gauge_pkg::P_1E11, gauge_pkg::P_3E02) &&
    in_range(rly_hi_q, gauge_pkg::P_1E11, gauge_pkg::P_3E02))
    else $error("relay setpoint out of range");
  a_auto_emission: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (auto_en_q && pres_q < auto_trip_q) |=> emission_high)
    else $error("auto switch did not select 4 mA");
  a_overp_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!eff_emis_hi && pres_q > overp_q) |=> !fil_on_q)
    else $error("filament on above overpressure limit");
  a_degas_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
    degas_min_q >= gauge_pkg::DEGAS_MIN_RST && degas_min_q <= gauge_pkg::DEGAS_MAX)
    else $error("degas time out of range");
endmodule

/* tb/pressure_source.sv */
// Chamber model: pressure moves one code step per cycle toward the target.
// Setpoints are therefore crossed gradually, as a real pump-down would.
module pressure_source (
  input wire logic clk_sys,
  input wire logic [7:0] target,
  output logic [7:0] pressure_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // The chamber starts vented, well above every setpoint.
  logic [7:0] level_q = 8'hA8;
  assign pressure_code = level_q;
  always @(posedge clk_sys) begin
    if (level_q < target) begin
      level_q <= level_q + 8'h01;
    end else if (level_q > target) begin
      level_q <= level_q - 8'h01;
    end
  end
endmodule

/* tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic fil_one_drive, fil_two_drive, degas_drive, emission_high, relay_drive;
  logic [7:0] awaddr, araddr, target, pressure_code, node_address;
  logic [31:0] wdata, rdata, rd, lfsr_q;
  logic [3:0] wstrb, baud_select;
  logic [1:0] bresp, rresp, rsp;
  logic [6:0] sensitivity;
  int err_total, n_compared;
  int m[16];
  logic [7:0] ta[12] = '{8'h04, 8'h04, 8'h04, 8'h0C, 8'h0C, 8'h0C, 8'h10, 8'h14, 8'h14, 8'h14,
                         8'h18, 8'h18};
  int td[12] = '{1, 11, 10, 15, 163, 85, 163, 95, 129, 112, 165, 160};

  gauge_setpoint_control #(.TICK_CYCLES(4)) i_gauge_setpoint_control (
    .clk_sys(clk_sys), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pressure_code(pressure_code), .fil_one_drive(fil_one_drive),
    .fil_two_drive(fil_two_drive), .degas_drive(degas_drive), .emission_high(emission_high),
    .relay_drive(relay_drive), .sensitivity(sensitivity), .node_address(node_address),
    .baud_select(baud_select));
  pressure_source i_pressure_source (.clk_sys(clk_sys), .target(target),
    .pressure_code(pressure_code));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (awvalid === 1'b1 && awready === 1'b1) begin aw = 1; awvalid <= 1'b0; end
      if (wvalid === 1'b1 && wready === 1'b1) begin w = 1; wvalid <= 1'b0; end
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Writes through the bus and applies the same write to the reference model.
  task automatic wr(input logic [7:0] a, input int d);
    axi_wr(a, d);
    case (a)
      8'h04: if (d >= 2 && d <= 10) m[1] = d;
      8'h08: if (d >= 2 && d <= 99) m[2] = d;
      8'h0C, 8'h10: if (d >= gauge_pkg::P_1E11 && d <= gauge_pkg::P_3E02) m[a >> 2] = d;
      8'h14: if (d >= gauge_pkg::P_1E06 && d <= gauge_pkg::P_1E04) m[5] = d;
      8'h18: if (d <= gauge_pkg::P_5E02) m[6] = d;
      8'h1C: m[7] = d & 4095;
      default: ;
    endcase
    chk({30'h0, rsp}, (a >= 8'h20) ? 32'h2 : 32'h0);
  endtask

  task automatic rdchk(input logic [7:0] a);
    axi_rd(a);
    chk(rd, m[a >> 2]);
    chk({30'h0, rsp}, 32'h0);
  endtask

  task automatic pres(input logic [7:0] p);
    target <= p;
    repeat (300) @(posedge clk_sys);
  endtask

  task automatic ctl(input int bits);
    wr(8'h00, bits);
    repeat (300) @(posedge clk_sys);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    final_report();
  end

  initial begin
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    target = 8'h50;
    err_total = 0;
    n_compared = 0;
    lfsr_q = 32'h32580319;
    m = '{default: 0};
    m[1] = 2;
    m[2] = 10;
    m[3] = 8'h60;
    m[4] = 8'h64;
    m[5] = 8'h80;
    m[6] = 8'hA4;
    m[7] = 12'h401;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk({30'h0, fil_one_drive, fil_two_drive}, 32'h0);
    chk({29'h0, degas_drive, relay_drive, emission_high}, 32'h0);
    chk({24'h0, node_address}, 32'h01);
    chk({28'h0, baud_select}, 32'h4);
    for (int a = 4; a <= 8'h34; a += 4) begin
      if (a < 8'h20 || a >= 8'h28) rdchk(8'(a));
    end
    axi_rd(8'h3C);
    chk({30'h0, rsp}, 32'h2);
    chk(rd, 32'h0);
    wr(8'h20, 5);
    for (int i = 0; i < 12; i++) begin
      wr(ta[i], td[i]);
      rdchk(ta[i]);
    end
    for (int i = 0; i < 6; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wr(8'h08, lfsr_q[6:0]);
      rdchk(8'h08);
      chk({25'h0, sensitivity}, m[2]);
    end
    wr(8'h1C, 12'h35F);
    chk({24'h0, node_address}, 32'h5F);
    chk({28'h0, baud_select}, 32'h3);
    wr(8'h0C, 8'h60);
    wr(8'h10, 8'h64);
    pres(8'h50);
    chk_pin(relay_drive, 1);
    pres(8'h62);
    chk_pin(relay_drive, 1);
    pres(8'h70);
    chk_pin(relay_drive, 0);
    pres(8'h62);
    chk_pin(relay_drive, 0);
    wr(8'h0C, 8'h70);
    wr(8'h10, 8'h60);
    pres(8'h80);
    chk_pin(relay_drive, 1);
    pres(8'h65);
    chk_pin(relay_drive, 1);
    pres(8'h50);
    chk_pin(relay_drive, 0);
    ctl(8'hC0);
    chk_pin(relay_drive, 1);
    ctl(8'h40);
    chk_pin(relay_drive, 0);
    wr(8'h0C, 8'h60);
    wr(8'h10, 8'h64);
    ctl(1 << gauge_pkg::CTRL_FIL_ON);
    chk({30'h0, fil_one_drive, fil_two_drive}, 32'h2);
    wr(8'h00, 1 << gauge_pkg::CTRL_DEGAS_ON);
    repeat (10) @(posedge clk_sys);
    chk_pin(degas_drive, 1);
    // Degas time is 10 minutes of 240 cycles here; it must still run near the end.
    repeat (2140) @(posedge clk_sys);
    chk_pin(degas_drive, 1);
    repeat (400) @(posedge clk_sys);
    chk({30'h0, degas_drive, fil_one_drive}, 32'h1);
    ctl(1 << gauge_pkg::CTRL_DEGAS_ON);
    chk_pin(degas_drive, 1);
    ctl(1 << gauge_pkg::CTRL_DEGAS_OFF);
    chk_pin(degas_drive, 0);
    ctl(1 << gauge_pkg::CTRL_FIL_OFF);
    chk_pin(fil_one_drive, 0);
    ctl(1 << gauge_pkg::CTRL_DEGAS_ON);
    chk_pin(degas_drive, 0);
    ctl((1 << gauge_pkg::CTRL_FIL_ON) | (1 << gauge_pkg::CTRL_FIL_SEL));
    chk({30'h0, fil_one_drive, fil_two_drive}, 32'h1);
    pres(8'hA6);
    chk_pin(fil_two_drive, 0);
    pres(8'h50);
    ctl(1 << gauge_pkg::CTRL_AUTO_EN);
    chk_pin(emission_high, 1);
    pres(8'h78);
    chk_pin(emission_high, 0);
    pres(8'h50);
    ctl(0);
    chk_pin(emission_high, 0);
    ctl(1 << gauge_pkg::CTRL_EMIS_HI);
    chk_pin(emission_high, 1);
    axi_rd(8'h24);
    chk(rd, 32'hC);
    axi_rd(8'h38);
    chk({31'h0, rd != 32'h0}, 32'h1);
    // Filament one ran for at least two tenth-hours, with a long degas on it.
    axi_rd(8'h28);
    chk({31'h0, rd >= 32'h2}, 32'h1);
    axi_rd(8'h30);
    chk({31'h0, rd != 32'h0}, 32'h1);
    axi_rd(8'h34);
    chk(rd, 32'h0);
    final_report();
  end
endmodule
